// >>> rudp_pkg.sv
// Overview of operation
// RULE1 - upper sixteen bits always read zero
// RULE2 - bits 15:10 hold writable user base
// RULE3 - bits 9:0 fixed zero, 1 KB steps
// RULE4 - reset clears base; zero means all kernel
// RULE5 - software keeps base above kernel base
// RULE6 - software keeps base within data RAM size
// RULE7 - writes to fixed bits are discarded
`default_nettype none
package rudp_pkg;
  // register offsets on the bus
  localparam logic [7:0] OFS_USER_BASE = 8'h00;
  localparam logic [7:0] OFS_KERNEL_BASE = 8'h04;
  localparam logic [7:0] OFS_RAM_SIZE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // base field layout and reset
  localparam int FIELD_LSB = 10;
  localparam int FIELD_MSB = 15;
  localparam int FIELD_W = 6;
  localparam int FIELD_LANE = 1;
  localparam logic [5:0] FIELD_RST = 6'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  // status bit positions
  localparam int ST_REGION_EN = 0;
  localparam int ST_ABOVE_KERNEL = 1;
  localparam int ST_WITHIN_SIZE = 2;
  localparam int ST_FAULT = 3;
  localparam logic [3:0] STATUS_RST = 4'h0;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // true for any mapped register offset
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == OFS_USER_BASE) || (a == OFS_KERNEL_BASE) || (a == OFS_RAM_SIZE) || (a == OFS_STATUS);
  endfunction : addr_hit

  // places a base field into its word, other bits zero
  function automatic logic [31:0] field_word(input logic [5:0] f);
    return {16'h0000, f, 10'h000};
  endfunction : field_word
endpackage : rudp_pkg
`default_nettype wire

// >>> rudp_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
// register access between bus slave and register file
interface rudp_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr, input rd_data);
  modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr, output rd_data);
endinterface : rudp_reg_if
`default_nettype wire

// >>> rudp_region_check.sv
`timescale 1ns/1ps
`default_nettype none
module rudp_region_check (
  // programmed fields
  input wire logic [5:0] i_user_field,
  input wire logic [5:0] i_kernel_field,
  input wire logic [31:0] i_ram_size,
  // placement flags
  output logic o_region_en,
  output logic o_above_kernel,
  output logic o_within_size,
  output logic o_fault
);
  logic [31:0] user_word;
  logic [31:0] kernel_word;

  // compare the boundary against kernel base and ram size
  always_comb
  begin
    user_word = rudp_pkg::field_word(i_user_field);
    kernel_word = rudp_pkg::field_word(i_kernel_field);
    o_region_en = (i_user_field != rudp_pkg::FIELD_RST); // RULE4
    o_above_kernel = user_word > kernel_word; // RULE5
    o_within_size = user_word <= i_ram_size; // RULE6
    o_fault = o_region_en && !(o_above_kernel && o_within_size);
  end
endmodule : rudp_region_check
`default_nettype wire

// >>> rudp_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module rudp_axil_slave (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // write address and data
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // read channels
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // register side
  rudp_reg_if.bus rif
);
  logic aw_full;
  logic w_full;
  logic commit;

  assign commit = aw_full && w_full && !o_bvalid;
  assign rif.rd_addr = i_araddr;

  // write address holding, released by the response
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_full <= 1'b0;
      o_awready <= 1'b1;
      rif.wr_addr <= 8'h00;
    end
    else if (i_awvalid && o_awready)
    begin
      aw_full <= 1'b1;
      o_awready <= 1'b0;
      rif.wr_addr <= i_awaddr;
    end
    else if (o_bvalid && i_bready)
    begin
      aw_full <= 1'b0;
      o_awready <= 1'b1;
    end
  end

  // write data holding, released by the response
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      w_full <= 1'b0;
      o_wready <= 1'b1;
      rif.wr_data <= 32'h0000_0000;
      rif.wr_strb <= 4'h0;
    end
    else if (i_wvalid && o_wready)
    begin
      w_full <= 1'b1;
      o_wready <= 1'b0;
      rif.wr_data <= i_wdata;
      rif.wr_strb <= i_wstrb;
    end
    else if (o_bvalid && i_bready)
    begin
      w_full <= 1'b0;
      o_wready <= 1'b1;
    end
  end

  // one write pulse and the response once both halves are held
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rif.wr_en <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= rudp_pkg::RESP_OKAY;
    end
    else
    begin
      rif.wr_en <= commit;
      if (commit)
      begin
        o_bvalid <= 1'b1;
        o_bresp <= rudp_pkg::addr_hit(rif.wr_addr) ? rudp_pkg::RESP_OKAY : rudp_pkg::RESP_SLVERR;
      end
      else if (i_bready)
        o_bvalid <= 1'b0;
    end
  end

  // read: data sampled at the address handshake
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= rudp_pkg::RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rif.rd_data;
      o_rresp <= rudp_pkg::addr_hit(i_araddr) ? rudp_pkg::RESP_OKAY : rudp_pkg::RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule : rudp_axil_slave
`default_nettype wire

// >>> ram_user_data_partition.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rudp_ram_user_data_partition #(
  parameter logic [31:0] DATA_RAM_SIZE = 32'h0000_8000
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  // axi4-lite write response
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // partition boundary to the ram arbiter
  output logic [31:0] o_user_data_base_offset,
  output logic [31:0] o_kernel_program_base_offset,
  output logic o_user_region_en,
  output logic o_partition_fault
);
  rudp_reg_if rif ();

  logic [5:0] user_field;
  logic [5:0] kernel_field;
  logic [3:0] status;
  logic chk_en;
  logic chk_above;
  logic chk_within;
  logic chk_fault;
  logic [7:0] rd_addr_q;
  logic rd_hit_q;
  logic wr_lane;
  logic user_wr;
  logic kernel_wr;

  // bus slave
  rudp_axil_slave rudp_axil_slave_i (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_awaddr(i_s_axi_awaddr),
    .i_awvalid(i_s_axi_awvalid),
    .o_awready(o_s_axi_awready),
    .i_wdata(i_s_axi_wdata),
    .i_wstrb(i_s_axi_wstrb),
    .i_wvalid(i_s_axi_wvalid),
    .o_wready(o_s_axi_wready),
    .o_bresp(o_s_axi_bresp),
    .o_bvalid(o_s_axi_bvalid),
    .i_bready(i_s_axi_bready),
    .i_araddr(i_s_axi_araddr),
    .i_arvalid(i_s_axi_arvalid),
    .o_arready(o_s_axi_arready),
    .o_rdata(o_s_axi_rdata),
    .o_rresp(o_s_axi_rresp),
    .o_rvalid(o_s_axi_rvalid),
    .i_rready(i_s_axi_rready),
    .rif(rif.bus)
  );

  // placement checks
  rudp_region_check rudp_region_check_i (
    .i_user_field(user_field),
    .i_kernel_field(kernel_field),
    .i_ram_size(DATA_RAM_SIZE),
    .o_region_en(chk_en),
    .o_above_kernel(chk_above),
    .o_within_size(chk_within),
    .o_fault(chk_fault)
  );

  // byte lane that carries the base field
  assign wr_lane = rif.wr_strb[rudp_pkg::FIELD_LANE];

  // committed writes that reach the base fields
  assign user_wr = rif.wr_en && rif.wr_addr == rudp_pkg::OFS_USER_BASE && wr_lane;
  assign kernel_wr = rif.wr_en && rif.wr_addr == rudp_pkg::OFS_KERNEL_BASE && wr_lane;

  // user base field; only bits 15:10 are stored
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      user_field <= rudp_pkg::FIELD_RST; // RULE4
    else if (rif.wr_en && rif.wr_addr == rudp_pkg::OFS_USER_BASE && wr_lane)
      user_field <= rif.wr_data[rudp_pkg::FIELD_MSB:rudp_pkg::FIELD_LSB]; // RULE2 RULE7
  end

  // kernel program base field, same layout
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      kernel_field <= rudp_pkg::FIELD_RST;
    else if (rif.wr_en && rif.wr_addr == rudp_pkg::OFS_KERNEL_BASE && wr_lane)
      kernel_field <= rif.wr_data[rudp_pkg::FIELD_MSB:rudp_pkg::FIELD_LSB];
  end

  // registered placement status
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      status <= rudp_pkg::STATUS_RST;
    else
    begin
      status[rudp_pkg::ST_REGION_EN] <= chk_en;
      status[rudp_pkg::ST_ABOVE_KERNEL] <= chk_above; // RULE5
      status[rudp_pkg::ST_WITHIN_SIZE] <= chk_within; // RULE6
      status[rudp_pkg::ST_FAULT] <= chk_fault;
    end
  end

  // boundary outputs, fixed bits are constant zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_user_data_base_offset <= rudp_pkg::WORD_RST; // RULE4
      o_kernel_program_base_offset <= rudp_pkg::WORD_RST;
      o_user_region_en <= 1'b0;
      o_partition_fault <= 1'b0;
    end
    else
    begin
      o_user_data_base_offset <= rudp_pkg::field_word(user_field); // RULE1 RULE3
      o_kernel_program_base_offset <= rudp_pkg::field_word(kernel_field);
      o_user_region_en <= chk_en; // RULE4
      o_partition_fault <= chk_fault; // RULE5 RULE6
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    case (rif.rd_addr)
      rudp_pkg::OFS_USER_BASE: rif.rd_data = rudp_pkg::field_word(user_field); // RULE1 RULE3
      rudp_pkg::OFS_KERNEL_BASE: rif.rd_data = rudp_pkg::field_word(kernel_field);
      rudp_pkg::OFS_RAM_SIZE: rif.rd_data = DATA_RAM_SIZE;
      rudp_pkg::OFS_STATUS: rif.rd_data = {28'h000_0000, status};
      default: rif.rd_data = 32'h0000_0000;
    endcase
  end

  // helper: address of the read being answered
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rd_addr_q <= 8'h00;
      rd_hit_q <= 1'b0;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      rd_addr_q <= i_s_axi_araddr;
      rd_hit_q <= rudp_pkg::addr_hit(i_s_axi_araddr);
    end
  end

  // upper half of the user base reads zero
  chk_upper_zero: assert property ( // RULE1
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_s_axi_rvalid && rd_addr_q == rudp_pkg::OFS_USER_BASE |-> o_s_axi_rdata[31:16] == 16'h0000)
    else $error("user base upper half not zero");

  // low ten bits read zero
  chk_low_fixed: assert property ( // RULE3
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_s_axi_rvalid && rd_addr_q == rudp_pkg::OFS_USER_BASE |-> o_s_axi_rdata[9:0] == 10'h000)
    else $error("user base low bits not zero");

  // a write to the field lands on the output two edges later
  chk_field_write: assert property ( // RULE2
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    rif.wr_en && rif.wr_addr == rudp_pkg::OFS_USER_BASE && wr_lane
    |-> ##2 o_user_data_base_offset[15:10] == $past(rif.wr_data[15:10], 2))
    else $error("user base write not stored");

  // writes that miss the lane or register leave the field alone
  chk_field_hold: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !(rif.wr_en && rif.wr_addr == rudp_pkg::OFS_USER_BASE && wr_lane) |=> $stable(user_field))
    else $error("user base changed without a write");

  // no write ever sets fixed or unimplemented bits
  chk_fixed_bits: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    rif.wr_en ##1 1'b1 ##1 1'b1 |-> o_user_data_base_offset[31:16] == 16'h0000
    && o_user_data_base_offset[9:0] == 10'h000)
    else $error("fixed bits of user base written");

  // after reset release the base is zero and no user region exists
  chk_reset_zero: assert property ( // RULE4
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> user_field == 6'h00 && o_user_data_base_offset == 32'h0000_0000 && !o_user_region_en)
    else $error("user base not cleared by reset");

  // region flag follows the field one edge later
  chk_region_flag: assert property ( // RULE4
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    ##1 o_user_region_en == ($past(user_field) != 6'h00))
    else $error("region flag wrong");

  // fault flag rises for a boundary at or below the kernel base
  chk_fault_flag: assert property ( // RULE5
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(user_field) != 6'h00 && $past(kernel_field) >= $past(user_field) |-> o_partition_fault)
    else $error("fault not raised below kernel base");

  // read answer follows the address handshake by one edge with the matching response code
  chk_read_answer: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && (o_s_axi_rresp == rudp_pkg::RESP_OKAY) == rd_hit_q)
    else $error("read answer late or wrong response");

  // read data held while the master stalls
  chk_read_hold: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped under stall");

  // boundary beyond the ram size raises the fault
  chk_size_fault: assert property ( // RULE6
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(user_field) != 6'h00 && rudp_pkg::field_word($past(user_field)) > DATA_RAM_SIZE |-> o_partition_fault)
    else $error("fault not raised beyond ram size");

  // zero field or legal placement keeps the fault low
  chk_fault_clear: assert property ( // RULE4
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(user_field) == 6'h00 || ($past(kernel_field) < $past(user_field)
    && rudp_pkg::field_word($past(user_field)) <= DATA_RAM_SIZE) |-> !o_partition_fault)
    else $error("fault raised for legal placement");

  // a kernel base write lands on its output two edges later
  chk_kernel_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    kernel_wr |-> ##2 o_kernel_program_base_offset[15:10] == $past(rif.wr_data[15:10], 2))
    else $error("kernel base write not stored");

  // kernel field changes only on its own write
  chk_kernel_hold: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !kernel_wr |=> $stable(kernel_field))
    else $error("kernel base changed without a write");

  // write response held while the master stalls
  chk_resp_hold: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped under stall");

  // one register write per response
  chk_write_pulse: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    rif.wr_en == $rose(o_s_axi_bvalid))
    else $error("write pulse not paired with response");

  // response code follows the address map
  chk_write_resp: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_s_axi_bvalid)
    |-> (o_s_axi_bresp == rudp_pkg::RESP_OKAY) == rudp_pkg::addr_hit(rif.wr_addr))
    else $error("write response code wrong");

  // no new write taken while a response is pending
  chk_busy_ready: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write accepted during pending response");

  // size register reads the configured ram size
  chk_size_read: assert property ( // RULE6
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_s_axi_rvalid && rd_addr_q == rudp_pkg::OFS_RAM_SIZE |-> o_s_axi_rdata == DATA_RAM_SIZE)
    else $error("ram size read wrong");

  // unmapped reads give zero and an error code
  chk_unmapped_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_s_axi_rvalid && !rd_hit_q
    |-> o_s_axi_rdata == 32'h0000_0000 && o_s_axi_rresp == rudp_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");

  // main scenarios
  cov_user_region: cover property (
    @(posedge i_sys_clk) disable iff (!i_rst_n) $rose(o_user_region_en));
  cov_fault: cover property (
    @(posedge i_sys_clk) disable iff (!i_rst_n) $rose(o_partition_fault));
  cov_read_base: cover property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_s_axi_rvalid && rd_addr_q == rudp_pkg::OFS_USER_BASE && o_s_axi_rdata != 32'h0000_0000);
  cov_unmapped: cover property (
    @(posedge i_sys_clk) disable iff (!i_rst_n) o_s_axi_bvalid && o_s_axi_bresp == rudp_pkg::RESP_SLVERR);
  cov_lane_skip: cover property (
    @(posedge i_sys_clk) disable iff (!i_rst_n) rif.wr_en && rif.wr_addr == rudp_pkg::OFS_USER_BASE && !wr_lane);
endmodule : rudp_ram_user_data_partition
`default_nettype wire

// >>> rudp_ram_user_data_partition_test.sv
`timescale 1ns/1ps
`default_nettype none
module rudp_ram_user_data_partition_test;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, region_en, fault;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, user_base, kern_base;
  int error_cnt = 0;
  int checked = 0;
  localparam logic [31:0] RAM_SIZE = 32'h0000_8000;

  // device under test
  rudp_ram_user_data_partition #(.DATA_RAM_SIZE(RAM_SIZE)) rudp_ram_user_data_partition_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_user_data_base_offset(user_base), .o_kernel_program_base_offset(kern_base),
    .o_user_region_en(region_en), .o_partition_fault(fault)
  );

  // 40 mhz system clock
  always #12.5 i_sys_clk = ~i_sys_clk;

  // verdict and end of run
  task automatic finish_test();
    $display("checked %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // bounded wait ran out
  task automatic timeout();
    error_cnt++;
    $display("Error at %0t: bus wait timed out", $time);
    finish_test();
  endtask : timeout

  // word compare
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_word

  // response code compare
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s response %h expected %h", $time, what, got, exp);
    end
  endtask : chk_resp

  // flag compare
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s flag %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // axi4-lite write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic [1:0] r;
    @(posedge i_sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_sys_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) timeout();
    else chk_resp(r, er, "write");
  endtask : axi_wr

  // axi4-lite read with expected data and response
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge i_sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_sys_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        chk_word(rdata, ed, "read data");
        chk_resp(rresp, er, "read");
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) timeout();
  endtask : axi_rd

  // let the field reach the partition outputs
  task automatic settle();
    repeat (3) @(posedge i_sys_clk);
  endtask : settle

  // reset pulse held three edges
  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
  endtask : do_reset

  // reset state of register and outputs
  task automatic t_reset();
    axi_rd(rudp_pkg::OFS_USER_BASE, 32'h0, rudp_pkg::RESP_OKAY);
    chk_word(user_base, 32'h0, "user base out");
    chk_bit(region_en, 1'b0, "region enable");
    chk_bit(fault, 1'b0, "fault");
    $display("test reset done");
  endtask : t_reset

  // only bits 15:10 keep written data
  task automatic t_fields();
    logic [31:0] wv [4] = '{32'hffff_ffff, 32'h0000_03ff, 32'h1234_0400, 32'hffff_83ff};
    logic [31:0] ev [4] = '{32'h0000_fc00, 32'h0000_0000, 32'h0000_0400, 32'h0000_8000};
    for (int k = 0; k < 4; k++)
    begin
      axi_wr(rudp_pkg::OFS_USER_BASE, wv[k], 4'hf, rudp_pkg::RESP_OKAY);
      settle();
      axi_rd(rudp_pkg::OFS_USER_BASE, ev[k], rudp_pkg::RESP_OKAY);
      chk_word(user_base, ev[k], "user base out");
      chk_bit(region_en, ev[k] != 32'h0, "region enable");
    end
    $display("test fields done");
  endtask : t_fields

  // byte lane 1 disabled leaves the field alone
  task automatic t_strobe();
    axi_wr(rudp_pkg::OFS_USER_BASE, 32'h0000_0c00, 4'hf, rudp_pkg::RESP_OKAY);
    axi_wr(rudp_pkg::OFS_USER_BASE, 32'hffff_ffff, 4'hd, rudp_pkg::RESP_OKAY);
    settle();
    axi_rd(rudp_pkg::OFS_USER_BASE, 32'h0000_0c00, rudp_pkg::RESP_OKAY);
    $display("test strobe done");
  endtask : t_strobe

  // placement against kernel base and ram size
  task automatic t_place();
    logic [31:0] uv [4] = '{32'h0000_0400, 32'h0000_0c00, 32'h0000_fc00, 32'h0000_8000};
    logic fv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [31:0] st_exp [4] = '{32'h0000_000d, 32'h0000_0007, 32'h0000_000b, 32'h0000_0007};
    axi_wr(rudp_pkg::OFS_KERNEL_BASE, 32'h0000_0800, 4'hf, rudp_pkg::RESP_OKAY);
    axi_rd(rudp_pkg::OFS_RAM_SIZE, RAM_SIZE, rudp_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      axi_wr(rudp_pkg::OFS_USER_BASE, uv[k], 4'hf, rudp_pkg::RESP_OKAY);
      settle();
      chk_bit(fault, fv[k], "placement fault");
      chk_word(kern_base, 32'h0000_0800, "kernel base out");
      axi_rd(rudp_pkg::OFS_STATUS, st_exp[k], rudp_pkg::RESP_OKAY);
    end
    axi_wr(rudp_pkg::OFS_KERNEL_BASE, 32'h0, 4'hf, rudp_pkg::RESP_OKAY);
    $display("test placement done");
  endtask : t_place

  // unmapped offset refused without effect
  task automatic t_unmapped();
    axi_wr(rudp_pkg::OFS_USER_BASE, 32'h0000_1400, 4'hf, rudp_pkg::RESP_OKAY);
    axi_wr(8'h10, 32'hffff_ffff, 4'hf, rudp_pkg::RESP_SLVERR);
    axi_rd(8'h10, 32'h0, rudp_pkg::RESP_SLVERR);
    axi_wr(rudp_pkg::OFS_RAM_SIZE, 32'h0, 4'hf, rudp_pkg::RESP_OKAY);
    axi_rd(rudp_pkg::OFS_RAM_SIZE, RAM_SIZE, rudp_pkg::RESP_OKAY);
    axi_rd(rudp_pkg::OFS_USER_BASE, 32'h0000_1400, rudp_pkg::RESP_OKAY);
    $display("test unmapped done");
  endtask : t_unmapped

  // reset in mid-run clears the field
  task automatic t_rst_mid();
    axi_wr(rudp_pkg::OFS_USER_BASE, 32'h0000_fc00, 4'hf, rudp_pkg::RESP_OKAY);
    settle();
    do_reset();
    @(posedge i_sys_clk);
    chk_word(user_base, 32'h0, "user base out");
    chk_bit(region_en, 1'b0, "region enable");
    axi_rd(rudp_pkg::OFS_USER_BASE, 32'h0, rudp_pkg::RESP_OKAY);
    $display("test mid reset done");
  endtask : t_rst_mid

  // main sequence
  initial
  begin
    do_reset();
    t_reset();
    t_fields();
    t_strobe();
    t_place();
    t_unmapped();
    t_rst_mid();
    finish_test();
  end
endmodule : rudp_ram_user_data_partition_test
`default_nettype wire
